// >>> rtl/umc_top.sv
// Purpose: mode control, pin ownership, wake, loopback and auto-rate for a serial port
// Assumes: avalon-mm slave, 100 MHz core_clk, pins synchronised here
// Notes: shifters are reduced to an 8N1 tx serialiser and an 8-bit rx level shift; fifo carries tx bytes to the pin logic
//
// Register access over Avalon-MM and the placing of the registers are this design's own decisions.
module umc_top (
	input wire logic core_clk, // 100 MHz clock
	input wire logic rst, // sync reset, high
	input wire logic [3:0] avs_address, // byte address
	input wire logic avs_read, // read strobe
	input wire logic avs_write, // write strobe
	input wire logic [31:0] avs_writedata, // write data
	output logic [31:0] avs_readdata, // read data
	output logic avs_waitrequest, // stall
	input wire logic idle_mode, // device idle
	input wire logic sleep_mode, // device sleep
	input wire logic receive_pin, // rx pin level
	input wire logic clear_to_send_pin, // cts pin, low active
	output logic transmit_pin_o, // tx drive value
	output logic transmit_pin_oe, // tx owned by port
	output logic request_to_send_pin_o, // rts/bclk value
	output logic request_to_send_pin_oe, // rts/bclk owned by port
	output logic rx_owned, // rx pin owned by port
	output logic cts_owned, // cts pin owned by port
	output logic port_clk_en, // clock gate for datapath
	output logic wake_event, // wake pulse
	output logic [15:0] rate_count // measured rate
);
	logic [15:0] mode_ff;
	logic [15:0] nxt_mode;
	logic rx_m_ff, rx_s_ff, rx_d_ff, cts_m_ff, cts_s_ff;
	logic wake_armed_ff;
	umc_pkg::umc_ab_e ab_st_ff;
	logic [2:0] ab_edges_ff;
	logic [15:0] ab_cnt_ff;
	logic ack_ff;
	logic on, run, ir, loop, rx_fall, rx_rise, rx_int, tx_raw, tx_line;
	logic [1:0] use_sel;
	logic [7:0] f_data;
	logic f_valid, f_ready, f_in_ready, tx_bit_ff;
	logic [3:0] ir_ph_ff;
	logic [3:0] tx_sh_ff;
	logic tx_busy_ff;
	logic [7:0] tx_byte_ff;
	logic [2:0] tx_idx_ff;
	logic [15:0] div_ff, tick_cnt_ff;
	logic tick;
	logic [7:0] rx_last_ff;

	assign on = mode_ff[umc_pkg::B_ON];
	assign ir = mode_ff[umc_pkg::B_IR] && !mode_ff[umc_pkg::B_HIGH_SPEED_RATE_GEN];
	assign loop = mode_ff[umc_pkg::B_LOOP];
	assign use_sel = mode_ff[umc_pkg::B_USE+1:umc_pkg::B_USE];
	assign run = on && !(idle_mode && mode_ff[umc_pkg::B_IDLE]);

	// two-stage synchronisers on the pins
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rx_m_ff <= 1'b1;
			rx_s_ff <= 1'b1;
			rx_d_ff <= 1'b1;
			cts_m_ff <= 1'b1;
			cts_s_ff <= 1'b1;
		end else begin
			rx_m_ff <= receive_pin;
			rx_s_ff <= rx_m_ff;
			rx_d_ff <= rx_int;
			cts_m_ff <= clear_to_send_pin;
			cts_s_ff <= cts_m_ff;
		end
	end

	// loopback takes the internal tx line instead of the pin
	assign rx_int = loop ? tx_line : rx_s_ff;
	assign rx_fall = rx_d_ff && !rx_int;
	assign rx_rise = !rx_d_ff && rx_int;

	// bus-visible mode word with hardware clears
	always_comb begin
		nxt_mode = mode_ff;
		// write lands on the edge where waitrequest is seen low
		if (avs_write && ack_ff && avs_address == umc_pkg::MODE_OFS) begin
			nxt_mode = avs_writedata[15:0] & umc_pkg::MODE_MASK;
		end
		// hardware clear wins only on the event edge itself
		if (wake_armed_ff && rx_rise) begin
			nxt_mode[umc_pkg::B_WAKE] = 1'b0;
		end
		if (ab_st_ff == umc_pkg::AB_MEAS && rx_fall && ab_edges_ff == 3'(umc_pkg::SYNC_EDGES - 1)) begin
			nxt_mode[umc_pkg::B_AUTO_RATE_DETECT] = 1'b0;
		end
	end

	// mode register
	always_ff @(posedge core_clk) begin
		if (rst) begin
			mode_ff <= umc_pkg::MODE_RST;
		end else begin
			mode_ff <= nxt_mode;
		end
	end

	// bus slave: one wait state, then ack
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ack_ff <= 1'b0;
			avs_readdata <= '0;
		end else begin
			ack_ff <= (avs_read || avs_write) && !ack_ff;
			if (avs_read && !ack_ff) begin
				case (avs_address)
					umc_pkg::MODE_OFS: avs_readdata <= {16'h0000, mode_ff};
					umc_pkg::STAT_OFS: avs_readdata <= {rate_count, 13'h0000, ab_st_ff, f_in_ready};
					umc_pkg::RXD_OFS: avs_readdata <= {24'h000000, rx_last_ff};
					default: avs_readdata <= 32'h00000000;
				endcase
			end
		end
	end
	assign avs_waitrequest = !ack_ff;

	// tx fifo accepts bytes written to the data offset while running
	umc_fifo #(
		.WIDTH(8),
		.DEPTH(umc_pkg::FIFO_DEPTH)
	) u_fifo (
		.core_clk(core_clk),
		.rst(rst),
		.in_data(avs_writedata[7:0]),
		.in_valid(avs_write && ack_ff && avs_address == umc_pkg::TXD_OFS && run),
		.in_ready(f_in_ready),
		.out_data(f_data),
		.out_valid(f_valid),
		.out_ready(f_ready)
	);

	// bit tick from the rate divider, stalls while stopped
	always_ff @(posedge core_clk) begin
		if (rst) begin
			div_ff <= umc_pkg::DIV_RST;
			tick_cnt_ff <= '0;
		end else begin
			if (avs_write && ack_ff && avs_address == umc_pkg::STAT_OFS) begin
				div_ff <= avs_writedata[15:0];
			end
			if (!run || tick) begin
				tick_cnt_ff <= '0;
			end else begin
				tick_cnt_ff <= tick_cnt_ff + 16'h0001;
			end
		end
	end
	assign tick = run && (tick_cnt_ff >= div_ff);

	// flow control: cts low lets the fifo drain only in cts mode
	assign f_ready = run && !tx_busy_ff && (use_sel != 2'b10 || !cts_s_ff);

	// simple serialiser, 8N1, start bit low
	always_ff @(posedge core_clk) begin
		if (rst) begin
			tx_busy_ff <= 1'b0;
			tx_byte_ff <= '0;
			tx_idx_ff <= '0;
			tx_sh_ff <= '0;
			tx_bit_ff <= 1'b1;
		end else if (!run) begin
			tx_busy_ff <= 1'b0;
			tx_bit_ff <= 1'b1;
			tx_sh_ff <= '0;
		end else if (f_valid && f_ready) begin
			tx_busy_ff <= 1'b1;
			tx_byte_ff <= f_data;
			tx_idx_ff <= '0;
			tx_sh_ff <= 4'h0;
			tx_bit_ff <= 1'b0;
		end else if (tx_busy_ff && tick) begin
			tx_sh_ff <= tx_sh_ff + 4'h1;
			if (tx_sh_ff == 4'h9) begin
				tx_busy_ff <= 1'b0;
				tx_bit_ff <= 1'b1;
			end else if (tx_sh_ff == 4'h8) begin
				tx_bit_ff <= 1'b1;
			end else begin
				tx_bit_ff <= tx_byte_ff[tx_idx_ff];
				tx_idx_ff <= tx_idx_ff + 3'h1;
			end
		end
	end

	// infrared pulse phase: high pulse while the bit is zero, in phases 0 to 2 of a free-running 16-cycle count not aligned to the bit
	always_ff @(posedge core_clk) begin
		if (rst || !ir || !run) begin
			ir_ph_ff <= '0;
		end else begin
			ir_ph_ff <= ir_ph_ff + 4'h1;
		end
	end
	assign tx_raw = tx_bit_ff;
	// encoder inverts a zero bit into a short high pulse
	assign tx_line = ir ? (!tx_raw && ir_ph_ff < 4'h3) : tx_raw;

	// received level shifted in per tick, decoder only inverts the level in infrared mode
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rx_last_ff <= '0;
		end else if (tick) begin
			rx_last_ff <= {rx_last_ff[6:0], ir ? !rx_int : rx_int};
		end
	end

	// wake: armed while sleeping with the wake bit set
	always_ff @(posedge core_clk) begin
		if (rst) begin
			wake_armed_ff <= 1'b0;
			wake_event <= 1'b0;
		end else begin
			wake_armed_ff <= on && sleep_mode && mode_ff[umc_pkg::B_WAKE];
			wake_event <= wake_armed_ff && rx_fall;
		end
	end

	// auto-rate: count core cycles across the falling edges of a 55h sync
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ab_st_ff <= umc_pkg::AB_IDLE;
			ab_edges_ff <= '0;
			ab_cnt_ff <= '0;
			rate_count <= '0;
		end else if (!run) begin
			ab_st_ff <= umc_pkg::AB_IDLE;
		end else begin
			case (ab_st_ff)
				umc_pkg::AB_IDLE: begin
					if (mode_ff[umc_pkg::B_AUTO_RATE_DETECT]) begin
						ab_st_ff <= umc_pkg::AB_WAIT;
					end
				end
				umc_pkg::AB_WAIT: begin
					if (!mode_ff[umc_pkg::B_AUTO_RATE_DETECT]) begin
						ab_st_ff <= umc_pkg::AB_IDLE;
					end else if (rx_fall) begin
						ab_st_ff <= umc_pkg::AB_MEAS;
						ab_edges_ff <= 3'h0;
						ab_cnt_ff <= '0;
					end
				end
				umc_pkg::AB_MEAS: begin
					ab_cnt_ff <= ab_cnt_ff + 16'h0001;
					if (rx_fall) begin
						ab_edges_ff <= ab_edges_ff + 3'h1;
						if (ab_edges_ff == 3'(umc_pkg::SYNC_EDGES - 1)) begin
							// 4 intervals of 2 bits each span 8 bit times; +1 counts this edge
							rate_count <= (ab_cnt_ff + 16'h0001) >> 3;
							ab_st_ff <= umc_pkg::AB_IDLE;
						end
					end
				end
				default: ab_st_ff <= umc_pkg::AB_IDLE;
			endcase
		end
	end

	// pin ownership and drive values
	always_ff @(posedge core_clk) begin
		if (rst) begin
			transmit_pin_o <= 1'b1;
			transmit_pin_oe <= 1'b0;
			request_to_send_pin_o <= 1'b1;
			request_to_send_pin_oe <= 1'b0;
			rx_owned <= 1'b0;
			cts_owned <= 1'b0;
			port_clk_en <= 1'b0;
		end else begin
			port_clk_en <= run;
			transmit_pin_oe <= on;
			rx_owned <= on;
			transmit_pin_o <= loop ? 1'b1 : tx_line;
			cts_owned <= on && use_sel == 2'b10;
			request_to_send_pin_oe <= on && use_sel != 2'b00;
			if (use_sel == 2'b11) begin
				request_to_send_pin_o <= tick; // baud clock out
			end else if (mode_ff[umc_pkg::B_RTS]) begin
				request_to_send_pin_o <= !tx_busy_ff; // simplex
			end else begin
				request_to_send_pin_o <= !f_in_ready; // flow control
			end
		end
	end

	// wake bit falls on the rx rise that follows the wake event
	property p_wake_clear;
		@(posedge core_clk) disable iff (rst)
		(wake_armed_ff && rx_rise) |=> !mode_ff[umc_pkg::B_WAKE];
	endproperty
	a_wake_clear: assert property (p_wake_clear) else $error("wake not cleared");
	property p_reserved;
		@(posedge core_clk) disable iff (rst)
		(mode_ff[14] == 1'b0) && (mode_ff[10] == 1'b0);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bit set");
	property p_off_pins;
		@(posedge core_clk) disable iff (rst)
		!on |=> !transmit_pin_oe && !request_to_send_pin_oe && !cts_owned;
	endproperty
	a_off_pins: assert property (p_off_pins) else $error("pins held while off");
	property p_on_tx;
		@(posedge core_clk) disable iff (rst)
		on |=> transmit_pin_oe && rx_owned;
	endproperty
	a_on_tx: assert property (p_on_tx) else $error("tx not owned");
	property p_idle_stop;
		@(posedge core_clk) disable iff (rst)
		(idle_mode && mode_ff[umc_pkg::B_IDLE]) |=> !port_clk_en;
	endproperty
	a_idle_stop: assert property (p_idle_stop) else $error("ran in idle");
	property p_use_rts;
		@(posedge core_clk) disable iff (rst)
		(on && use_sel == 2'b00) |=> !request_to_send_pin_oe;
	endproperty
	a_use_rts: assert property (p_use_rts) else $error("rts driven in mode 00");
	property p_loop_tx;
		@(posedge core_clk) disable iff (rst)
		loop |=> transmit_pin_o;
	endproperty
	a_loop_tx: assert property (p_loop_tx) else $error("tx active in loopback");
	property p_ab_clear;
		@(posedge core_clk) disable iff (rst)
		(ab_st_ff == umc_pkg::AB_MEAS && rx_fall && ab_edges_ff == 3'(umc_pkg::SYNC_EDGES - 1))
		|=> !mode_ff[umc_pkg::B_AUTO_RATE_DETECT] && ab_st_ff == umc_pkg::AB_IDLE;
	endproperty
	a_ab_clear: assert property (p_ab_clear) else $error("auto rate not cleared");
	property p_ir_hs;
		@(posedge core_clk) disable iff (rst)
		mode_ff[umc_pkg::B_HIGH_SPEED_RATE_GEN] |-> !ir;
	endproperty
	a_ir_hs: assert property (p_ir_hs) else $error("codec on at high speed");
endmodule

// >>> rtl/umc_pkg.sv
// Purpose: shared constants for the serial mode-control block
// Assumes: 32-bit avalon-mm slave, word addressed by byte offset
// Notes: register offsets are byte addresses
package umc_pkg;
	localparam logic [3:0] MODE_OFS = 4'h0;
	localparam logic [3:0] STAT_OFS = 4'h4;
	localparam logic [3:0] TXD_OFS = 4'h8;
	localparam logic [3:0] RXD_OFS = 4'hc;
	localparam int B_ON = 15;
	localparam int B_IDLE = 13;
	localparam int B_IR = 12;
	localparam int B_RTS = 11;
	localparam int B_USE = 8;
	localparam int B_WAKE = 7;
	localparam int B_LOOP = 6;
	localparam int B_AUTO_RATE_DETECT = 5;
	localparam int B_HIGH_SPEED_RATE_GEN = 3;
	// implemented bits; 14, 10, 4 and 2 to 0 read as zero
	localparam logic [15:0] MODE_MASK = 16'hbbe8;
	localparam logic [15:0] MODE_RST = 16'h0000;
	localparam logic [15:0] DIV_RST = 16'h0000;
	localparam int FIFO_DEPTH = 16;
	localparam int SYNC_EDGES = 4;
	typedef enum logic [1:0] {
		AB_IDLE = 2'b00,
		AB_WAIT = 2'b01,
		AB_MEAS = 2'b10
	} umc_ab_e;
endpackage

// >>> rtl/umc_fifo.sv
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: single clock, synchronous active-high reset
// Notes: read data come from a register
module umc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic core_clk, // clock
	input wire logic rst, // sync reset
	input wire logic [WIDTH-1:0] in_data, // write data
	input wire logic in_valid, // write request
	output logic in_ready, // not full
	output logic [WIDTH-1:0] out_data, // read data
	output logic out_valid, // not empty
	input wire logic out_ready // drain
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wp_ff, rp_ff;
	logic full, empty, push, pop;
	assign full = (wp_ff[AW] != rp_ff[AW]) && (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
	assign empty = (wp_ff == rp_ff);
	assign in_ready = !full;
	assign push = in_valid && !full;
	assign pop = out_valid && out_ready;
	// storage writes, no reset needed
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wp_ff[AW-1:0]] <= in_data;
		end
	end
	// pointers and registered head
	always_ff @(posedge core_clk) begin
		if (rst) begin
			wp_ff <= '0;
			rp_ff <= '0;
			out_valid <= 1'b0;
			out_data <= '0;
		end else begin
			if (push) begin
				wp_ff <= wp_ff + 1'b1;
			end
			if ((!out_valid || pop) && !empty) begin
				out_data <= mem[rp_ff[AW-1:0]];
				rp_ff <= rp_ff + 1'b1;
				out_valid <= 1'b1;
			end else if (pop) begin
				out_valid <= 1'b0;
			end
		end
	end
endmodule

// >>> dv/umc_remote.sv
// Purpose: remote serial sender facing the port pins
// Assumes: bench calls the tasks; one bit lasts a whole number of core_clk cycles
// Notes: lines idle high like a pulled-up serial line; tx is only watched
module umc_remote (
	input wire logic core_clk, // bench clock
	input wire logic transmit_pin_o, // port tx value
	output logic receive_pin, // line into port rx
	output logic clear_to_send_pin // cts, low active
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle levels at time zero, so the port never sees a false start
	initial begin
		receive_pin = 1'b1;
		clear_to_send_pin = 1'b1;
	end
	// single level change, launched right after an edge
	task automatic set_rx(input logic v);
		@(posedge core_clk);
		receive_pin <= v;
	endtask
	// cts high stalls the port's sender in cts mode
	task automatic set_cts(input logic v);
		@(posedge core_clk);
		clear_to_send_pin <= v;
	endtask
	// start bit, eight data bits lsb first, stop bit
	task automatic send_byte(input logic [7:0] d, input int bit_cyc);
		logic [9:0] frame;
		frame = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge core_clk);
			receive_pin <= frame[i];
			repeat (bit_cyc - 1) @(posedge core_clk);
		end
	endtask
endmodule

// >>> dv/umc_top_tb.sv
// Purpose: self-checking bench for the serial mode-control block
// Assumes: avalon-mm master tasks wait on waitrequest; remote model drives the pins
// Notes: infrared codec path is only kept off the high-speed setting, not measured
module umc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic idle_mode = 1'b0;
	logic sleep_mode = 1'b0;
	logic receive_pin, clear_to_send_pin, transmit_pin_o, transmit_pin_oe;
	logic request_to_send_pin_o, request_to_send_pin_oe, rx_owned, cts_owned;
	logic port_clk_en, wake_event;
	logic [15:0] rate_count;
	int n_errors = 0;
	int samples_checked = 0;
	logic [31:0] rd;
	umc_top i_umc_top (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.idle_mode(idle_mode), .sleep_mode(sleep_mode), .receive_pin(receive_pin),
		.clear_to_send_pin(clear_to_send_pin), .transmit_pin_o(transmit_pin_o),
		.transmit_pin_oe(transmit_pin_oe), .request_to_send_pin_o(request_to_send_pin_o),
		.request_to_send_pin_oe(request_to_send_pin_oe), .rx_owned(rx_owned),
		.cts_owned(cts_owned), .port_clk_en(port_clk_en), .wake_event(wake_event),
		.rate_count(rate_count));
	umc_remote i_umc_remote (.core_clk(core_clk), .transmit_pin_o(transmit_pin_o),
		.receive_pin(receive_pin), .clear_to_send_pin(clear_to_send_pin));
	// 100 MHz clock
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// request held until waitrequest is sampled low at an edge
	task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= 1'b1;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
	endtask
	task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
		@(posedge core_clk);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		d = avs_readdata;
		avs_read <= 1'b0;
	endtask
	// set the mode and give the pins time to follow
	task automatic set_mode(input logic [15:0] m);
		bus_write(umc_pkg::MODE_OFS, {16'h0, m});
		repeat (3) @(posedge core_clk);
	endtask
	task automatic t_mode_bits;
		bus_read(umc_pkg::MODE_OFS, rd);
		check(rd, 32'h0);
		bus_write(umc_pkg::MODE_OFS, 32'h0000_ffff);
		bus_read(umc_pkg::MODE_OFS, rd);
		check(rd, {16'h0, umc_pkg::MODE_MASK});
		bus_write(4'h2, 32'h0000_ffff);
		bus_read(4'h2, rd);
		check(rd, 32'h0);
		set_mode(16'h0000);
		check({transmit_pin_oe, request_to_send_pin_oe, rx_owned, cts_owned}, 4'h0);
		check(port_clk_en, 1'b0);
		$display("test mode_bits done");
	endtask
	task automatic t_pin_usage;
		for (int u = 0; u < 4; u++) begin
			set_mode(16'(32'h8000 | (u << umc_pkg::B_USE)));
			check({transmit_pin_oe, rx_owned}, 2'b11);
			check(cts_owned, u == 2);
			check(request_to_send_pin_oe, u != 0);
		end
		set_mode(16'h8900);
		check(request_to_send_pin_o, 1'b1);
		set_mode(16'h8100);
		check(request_to_send_pin_o, 1'b0);
		set_mode(16'h0300);
		check({transmit_pin_oe, request_to_send_pin_oe, rx_owned, cts_owned}, 4'h0);
		$display("test pin_usage done");
	endtask
	task automatic t_idle;
		set_mode(16'(32'h8000 | (1 << umc_pkg::B_IDLE)));
		check(port_clk_en, 1'b1);
		idle_mode <= 1'b1;
		repeat (3) @(posedge core_clk);
		check(port_clk_en, 1'b0);
		set_mode(16'h8000);
		check(port_clk_en, 1'b1);
		idle_mode <= 1'b0;
		$display("test idle done");
	endtask
	task automatic t_wake;
		int seen;
		seen = 0;
		sleep_mode <= 1'b1;
		set_mode(16'(32'h8000 | (1 << umc_pkg::B_WAKE)));
		i_umc_remote.set_rx(1'b0);
		repeat (10) begin
			@(posedge core_clk);
			if (wake_event === 1'b1) seen++;
		end
		check(seen, 1);
		bus_read(umc_pkg::MODE_OFS, rd);
		check(rd[umc_pkg::B_WAKE], 1'b1);
		i_umc_remote.set_rx(1'b1);
		repeat (8) @(posedge core_clk);
		bus_read(umc_pkg::MODE_OFS, rd);
		check(rd, 32'h0000_8000);
		sleep_mode <= 1'b0;
		$display("test wake done");
	endtask
	task automatic t_auto_rate;
		set_mode(16'(32'h8000 | (1 << umc_pkg::B_AUTO_RATE_DETECT)));
		bus_read(umc_pkg::MODE_OFS, rd);
		check(rd[umc_pkg::B_AUTO_RATE_DETECT], 1'b1);
		i_umc_remote.send_byte(8'h55, 16);
		repeat (10) @(posedge core_clk);
		bus_read(umc_pkg::MODE_OFS, rd);
		check(rd, 32'h0000_8000);
		bus_read(umc_pkg::STAT_OFS, rd);
		check(rd[31:16], 16'h0010);
		$display("test auto_rate done");
	endtask
	task automatic t_fifo;
		int n;
		set_mode(16'h8200);
		for (int i = 0; i <= umc_pkg::FIFO_DEPTH; i++) bus_write(umc_pkg::TXD_OFS, i);
		bus_read(umc_pkg::STAT_OFS, rd);
		check(rd[0], 1'b0);
		i_umc_remote.set_cts(1'b0);
		n = 0;
		do begin
			bus_read(umc_pkg::STAT_OFS, rd);
			n++;
		end while (rd[0] !== 1'b1 && n < 3000);
		check(rd[0], 1'b1);
		i_umc_remote.set_cts(1'b1);
		$display("test fifo done");
	endtask
	task automatic t_loop;
		set_mode(16'(32'h8000 | (1 << umc_pkg::B_LOOP)));
		bus_read(umc_pkg::MODE_OFS, rd);
		check(rd, 32'h0000_8040);
		check({transmit_pin_o, rx_owned}, 2'b11);
		set_mode(16'h0000);
		$display("test loop done");
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// watchdog, well beyond the expected run of a few hundred cycles
	initial begin
		#400us;
		n_errors++;
		report_and_stop();
	end
	// main sequence
	initial begin
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		t_mode_bits();
		t_pin_usage();
		t_idle();
		t_wake();
		t_auto_rate();
		t_fifo();
		t_loop();
		report_and_stop();
	end
endmodule
